// file: hdl/plc_link_area_and_status.sv
// Link area allocation, checking, station polling and status for two token links
//
// Contract
// R1: Peers share one relay used range.
// R2: Peers share one register used range.
// R3: 64 relay, 128 register words; beyond used range stays internal.
// R4: Bad area allocation flags an error and disables the link.
// R5: Sent words land at equal numbers; overlapping send areas are an error.
// R6: Split send areas or alternating send/receive segments are rejected.
// R7: Largest station bounds polling, one setting per link.
// R8: Peers share one largest station value.
// R9: Stations are numbered from 1 with no gaps.
// R10: Missing stations or high largest value lengthen the link cycle.
// R11: Switch flag selects the half of the link words.
// R12: One assurance bit per station, on only while its link is normal.
// R13: Check assurance before using received data.
// R14: One mode bit per station, on in run, off in program_stop_mode.
// R15: Error bit set on any link problem or bad area setting.
// R16: Link 1 relay words start at 64 and register words at 128.
// R17: Zero send size makes a station receive-only.
// R18: Assurance and mode bits update once per completed cycle.
//
// Our own choices: the strobed register port and the address map.
`include "plc_link_defs.svh"

module plc_link_area_and_status #(
   parameter int POLL_TIMEOUT_CYCLES = `POLL_TIMEOUT_US * `CLK_MHZ
) (
   input wire logic clock, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic [`ADDR_W-1:0] addr, // Register word address
   input wire logic [`DATA_W-1:0] wrData, // Write data
   input wire logic wrStb, // Write strobe
   input wire logic rdStb, // Read strobe
   output logic [`DATA_W-1:0] rdData, // Read data, cycle after rdStb
   output logic irq, // Level interrupt
   output logic linkErrFlag, // Transmission error indication
   output logic [1:0] pollReq, // Ask link framer to poll a station
   output plc_link_pkg::station_t pollStation [2], // Station being polled
   input wire logic [1:0] frameValid, // Polled station answered
   input wire logic [1:0] frameGood, // Answer passed line checks
   input wire logic [1:0] frameRun, // Answering station is in run mode
   input wire logic [6:0] frameRelayStart [2], // Send area start, relay words
   input wire logic [6:0] frameRelaySize [2], // Send area size, relay words
   input wire logic [7:0] frameRegStart [2], // Send area start, register words
   input wire logic [7:0] frameRegSize [2], // Send area size, register words
   input wire logic rxWordValid, // Received data word
   input wire logic rxLink, // Link it came from
   input wire logic rxIsReg, // Register word, else relay word
   input wire logic [7:0] rxIndex, // Absolute word number
   input wire logic [`WORD_W-1:0] rxData, // Word value
   output logic [1:0] txEnable, // Own station transmits on the link
   input wire logic txRdReq, // Framer fetches a word to send
   input wire logic txRdIsReg, // Register word, else relay word
   input wire logic [7:0] txRdIndex, // Absolute word number
   output logic [`WORD_W-1:0] txRdData, // Word value, cycle after txRdReq
   output logic [15:0] assure [2], // Per-station assurance bits
   output logic [15:0] runMode [2] // Per-station run mode bits
);
   import plc_link_pkg::*;

   logic [`WORD_W-1:0] relayMem [`RELAY_WORDS];
   logic [`WORD_W-1:0] regMem [`REG_WORDS];
   logic switchReg;
   station_t ownStationReg;
   logic ownRunReg;
   logic [`STATUS_W-1:0] statusReg;
   logic [`STATUS_W-1:0] maskReg;
   logic [`DATA_W-1:0] rdDataReg;
   logic errFlagReg;
   logic [`WORD_W-1:0] txRdDataReg;

   logic [1:0] evCfgErr;
   logic [1:0] evLinkErr;
   logic [1:0] evCycle;
   logic [1:0] rxOk;
   logic [`DATA_W-1:0] cfgRead [2];

   wire cfgWr0 = wrStb && (addr[9:4] == `A_LINK0_CFG >> 4);
   wire cfgWr1 = wrStb && (addr[9:4] == `A_LINK1_CFG >> 4);
   wire [1:0] cfgWr = {cfgWr1, cfgWr0};
   wire isRelayMem = (addr[9:7] == `A_RELAY_MEM >> 7);
   wire isRegMem = (addr[9:8] == `A_REG_MEM >> 8);

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : linkG
         logic [6:0] relayRangeReg;
         logic [7:0] regRangeReg;
         logic [6:0] relayStartReg;
         logic [6:0] relaySizeReg;
         logic [7:0] regStartReg;
         logic [7:0] regSizeReg;
         station_t maxStationReg;
         poll_state_e stateReg;
         station_t stationReg;
         logic [13:0] timerReg;
         logic [15:0] assureShadowReg;
         logic [15:0] modeShadowReg;
         logic [15:0] assureReg;
         logic [15:0] modeReg;
         logic [`RELAY_WORDS-1:0] claimRelayReg;
         logic [`REG_WORDS-1:0] claimRegReg;

         // Link 1 defaults to the upper half
         // R11 half select
         wire upperHalf = (g == 1) ^ switchReg;
         // R16 link 1 numbering
         wire [7:0] relayBase = upperHalf ? `LINK_RELAY_MAX : 8'd0;
         wire [8:0] regBase = upperHalf ? `LINK_REG_MAX : 9'd0;
         // R3 used range bounds
         wire [7:0] relayLim = relayBase + {1'b0, relayRangeReg};
         wire [8:0] regLim = regBase + {1'b0, regRangeReg};
         wire [7:0] ownRelayEnd = {1'b0, relayStartReg} + {1'b0, relaySizeReg};
         wire [8:0] ownRegEnd = {1'b0, regStartReg} + {1'b0, regSizeReg};

         // R6 send area contiguous and inside the receive space
         wire ownRelayOk = (relaySizeReg == 7'd0) ||
                           ({1'b0, relayStartReg} >= relayBase && ownRelayEnd <= relayLim);
         wire ownRegOk = (regSizeReg == 8'd0) ||
                         ({1'b0, regStartReg} >= regBase && ownRegEnd <= regLim);
         // R4 allocation check
         wire cfgOk = ({1'b0, relayRangeReg} <= `LINK_RELAY_MAX) && ({1'b0, regRangeReg} <= `LINK_REG_MAX) &&
                      ownRelayOk && ownRegOk && (maxStationReg != 5'd0) &&
                      (maxStationReg <= `MAX_STATIONS) && (ownStationReg != 5'd0) &&
                      (ownStationReg <= maxStationReg);
         wire used = (relayRangeReg != 7'd0) || (regRangeReg != 8'd0);
         wire enabled = used && cfgOk;
         // R17 receive-only
         wire sends = (relaySizeReg != 7'd0) || (regSizeReg != 8'd0);
         wire [`RELAY_WORDS-1:0] ownRelayMask = ~({`RELAY_WORDS{1'b1}} << relaySizeReg) << relayStartReg;
         wire [`REG_WORDS-1:0] ownRegMask = ~({`REG_WORDS{1'b1}} << regSizeReg) << regStartReg;

         // Checks on a peer answer
         wire [7:0] fRelayEnd = {1'b0, frameRelayStart[g]} + {1'b0, frameRelaySize[g]};
         wire [8:0] fRegEnd = {1'b0, frameRegStart[g]} + {1'b0, frameRegSize[g]};
         wire [`RELAY_WORDS-1:0] fRelayMask = ~({`RELAY_WORDS{1'b1}} << frameRelaySize[g]) << frameRelayStart[g];
         wire [`REG_WORDS-1:0] fRegMask = ~({`REG_WORDS{1'b1}} << frameRegSize[g]) << frameRegStart[g];
         // R5 area must exist locally at the same numbers
         wire fInRange = ((frameRelaySize[g] == 7'd0) ||
                          ({1'b0, frameRelayStart[g]} >= relayBase && fRelayEnd <= relayLim)) &&
                         ((frameRegSize[g] == 8'd0) ||
                          ({1'b0, frameRegStart[g]} >= regBase && fRegEnd <= regLim));
         // R5 overlapping send areas
         wire fOverlap = |(fRelayMask & claimRelayReg) || |(fRegMask & claimRegReg);
         wire isOwn = (stationReg == ownStationReg);
         wire peerOk = frameGood[g] && fInRange && !fOverlap;
         wire timedOut = (timerReg == 14'(POLL_TIMEOUT_CYCLES - 1));
         wire lastStation = (stationReg >= maxStationReg);
         wire [3:0] slot = 4'(stationReg - 5'd1);
         wire answered = (stateReg == POLL_WAIT) && frameValid[g];
         wire ownSkip = (stateReg == POLL_ASK) && isOwn && !sends;
         wire slotEnd = answered || ((stateReg == POLL_WAIT) && timedOut) || ownSkip;

         poll_state_e stateNext;
         always_comb begin
            stateNext = stateReg;
            case (stateReg)
               POLL_IDLE: stateNext = enabled ? POLL_ASK : POLL_IDLE;
               POLL_ASK: stateNext = ownSkip ? (lastStation ? POLL_DONE : POLL_ASK) : POLL_WAIT;
               // R10 absent stations cost a full timeout
               POLL_WAIT: if (slotEnd) begin
                  stateNext = lastStation ? POLL_DONE : POLL_ASK;
               end
               POLL_DONE: stateNext = POLL_IDLE;
               default: stateNext = POLL_IDLE;
            endcase
            if (!enabled) begin
               stateNext = POLL_IDLE;
            end
         end

         always_ff @(posedge clock) begin
            if (sys_rst) begin
               relayRangeReg <= 7'h00;
               regRangeReg <= 8'h00;
               relayStartReg <= (g == 1) ? `RST_RELAY_START1 : `RST_RELAY_START0;
               relaySizeReg <= 7'h00;
               regStartReg <= (g == 1) ? `RST_REG_START1 : `RST_REG_START0;
               regSizeReg <= 8'h00;
               maxStationReg <= `RST_MAX_STATION;
            end else if (cfgWr[g]) begin
               case (addr[3:0])
                  `C_RELAY_RANGE: relayRangeReg <= wrData[6:0];
                  `C_REG_RANGE: regRangeReg <= wrData[7:0];
                  `C_RELAY_START: relayStartReg <= wrData[6:0];
                  `C_RELAY_SIZE: relaySizeReg <= wrData[6:0];
                  `C_REG_START: regStartReg <= wrData[7:0];
                  `C_REG_SIZE: regSizeReg <= wrData[7:0];
                  // R7 largest station per link
                  `C_MAX_STATION: maxStationReg <= wrData[4:0];
                  default: ;
               endcase
            end
         end

         always_ff @(posedge clock) begin
            if (sys_rst) begin
               stateReg <= POLL_IDLE;
               stationReg <= 5'd1;
               timerReg <= 14'd0;
               assureShadowReg <= 16'h0000;
               modeShadowReg <= 16'h0000;
               assureReg <= 16'h0000;
               modeReg <= 16'h0000;
               claimRelayReg <= '0;
               claimRegReg <= '0;
            end else begin
               stateReg <= stateNext;
               timerReg <= (stateReg == POLL_WAIT && !slotEnd) ? timerReg + 14'd1 : 14'd0;
               if (stateReg == POLL_IDLE) begin
                  // R7 polling starts at station 1
                  stationReg <= 5'd1;
                  assureShadowReg <= 16'h0000;
                  modeShadowReg <= 16'h0000;
                  claimRelayReg <= ownRelayMask;
                  claimRegReg <= ownRegMask;
               end else if (slotEnd) begin
                  stationReg <= stationReg + 5'd1;
                  if (isOwn) begin
                     assureShadowReg[slot] <= 1'b1;
                     modeShadowReg[slot] <= ownRunReg;
                  end else if (answered && peerOk) begin
                     assureShadowReg[slot] <= 1'b1;
                     // R14 run versus program_stop_mode
                     modeShadowReg[slot] <= frameRun[g];
                     claimRelayReg <= claimRelayReg | fRelayMask;
                     claimRegReg <= claimRegReg | fRegMask;
                  end
               end
               // R18 commit once per cycle
               if (stateReg == POLL_DONE) begin
                  assureReg <= assureShadowReg;
                  modeReg <= modeShadowReg;
               // R12 off while the link is unused or disabled by a bad setting
               end else if (!enabled) begin
                  assureReg <= 16'h0000;
               end
            end
         end

         // R15 error sources
         assign evCfgErr[g] = used && !cfgOk;
         assign evLinkErr[g] = answered && !isOwn && !peerOk;
         assign evCycle[g] = (stateReg == POLL_DONE);
         assign pollReq[g] = (stateReg == POLL_ASK) && !ownSkip && enabled;
         assign pollStation[g] = stationReg;
         assign txEnable[g] = enabled && sends;
         assign assure[g] = assureReg;
         assign runMode[g] = modeReg;

         // R3 words beyond range, and own send area, never take link data
         wire [8:0] rxNum = {1'b0, rxIndex};
         wire rxInRange = rxIsReg ? (rxNum >= regBase && rxNum < regLim) :
                          (rxNum >= {1'b0, relayBase} && rxNum < {1'b0, relayLim});
         wire rxOwn = rxIsReg ? ownRegMask[rxIndex] : ownRelayMask[rxIndex[6:0]];
         assign rxOk[g] = enabled && rxInRange && !rxOwn;

         assign cfgRead[g] = (addr[3:0] == `C_RELAY_RANGE) ? 32'(relayRangeReg) :
                             (addr[3:0] == `C_REG_RANGE) ? 32'(regRangeReg) :
                             (addr[3:0] == `C_RELAY_START) ? 32'(relayStartReg) :
                             (addr[3:0] == `C_RELAY_SIZE) ? 32'(relaySizeReg) :
                             (addr[3:0] == `C_REG_START) ? 32'(regStartReg) :
                             (addr[3:0] == `C_REG_SIZE) ? 32'(regSizeReg) :
                             (addr[3:0] == `C_MAX_STATION) ? 32'(maxStationReg) : 32'd0;
      end
   endgenerate

   // On a clash with a bus write
   // the received word wins.
   wire rxAccept = rxWordValid && rxOk[rxLink];
   wire [`STATUS_W-1:0] events;
   assign events[`S_CFG_ERR +: 2] = evCfgErr;
   assign events[`S_LINK_ERR +: 2] = evLinkErr;
   assign events[`S_CYCLE +: 2] = evCycle;
   wire [`STATUS_W-1:0] statusClr = (wrStb && addr == `A_STATUS) ? wrData[`STATUS_W-1:0] : '0;

   wire [`DATA_W-1:0] rdSel =
      isRelayMem ? 32'(relayMem[addr[6:0]]) :
      isRegMem ? 32'(regMem[addr[7:0]]) :
      (addr[9:4] == `A_LINK0_CFG >> 4) ? cfgRead[0] :
      (addr[9:4] == `A_LINK1_CFG >> 4) ? cfgRead[1] :
      (addr == `A_SWITCH) ? 32'(switchReg) :
      (addr == `A_OWN_STATION) ? 32'(ownStationReg) :
      (addr == `A_OWN_RUN) ? 32'(ownRunReg) :
      (addr == `A_STATUS) ? 32'(statusReg) :
      (addr == `A_MASK) ? 32'(maskReg) :
      (addr == `A_ASSURE) ? {assure[1], assure[0]} :
      (addr == `A_MODE) ? {runMode[1], runMode[0]} : 32'd0;

   always_ff @(posedge clock) begin
      if (wrStb && isRelayMem) begin
         relayMem[addr[6:0]] <= wrData[15:0];
      end
      if (wrStb && isRegMem) begin
         regMem[addr[7:0]] <= wrData[15:0];
      end
      // R5 word lands at its own number
      if (rxAccept && !rxIsReg) begin
         relayMem[rxIndex[6:0]] <= rxData;
      end
      if (rxAccept && rxIsReg) begin
         regMem[rxIndex] <= rxData;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         switchReg <= 1'b0;
         ownStationReg <= 5'd1;
         ownRunReg <= 1'b0;
         statusReg <= '0;
         maskReg <= '0;
         rdDataReg <= 32'd0;
         errFlagReg <= 1'b0;
         txRdDataReg <= 16'h0000;
      end else begin
         if (wrStb && addr == `A_SWITCH) begin
            switchReg <= wrData[0];
         end
         if (wrStb && addr == `A_OWN_STATION) begin
            ownStationReg <= wrData[4:0];
         end
         if (wrStb && addr == `A_OWN_RUN) begin
            ownRunReg <= wrData[0];
         end
         if (wrStb && addr == `A_MASK) begin
            maskReg <= wrData[`STATUS_W-1:0];
         end
         // Set wins over a same-cycle clear
         statusReg <= (statusReg & ~statusClr) | events;
         // R15 error indication
         errFlagReg <= |(statusReg[`S_CFG_ERR +: 4] & ~statusClr[`S_CFG_ERR +: 4]) | |events[`S_CFG_ERR +: 4];
         rdDataReg <= rdStb ? rdSel : 32'd0;
         if (txRdReq) begin
            txRdDataReg <= txRdIsReg ? regMem[txRdIndex] : relayMem[txRdIndex[6:0]];
         end
      end
   end

   assign rdData = rdDataReg;
   assign irq = |(statusReg & maskReg);
   assign linkErrFlag = errFlagReg;
   assign txRdData = txRdDataReg;
endmodule : plc_link_area_and_status

// file: pkg/plc_link_defs.svh
// Constants of the shared link area block: offsets, fields, reset values, timing
`ifndef PLC_LINK_DEFS_SVH
`define PLC_LINK_DEFS_SVH

`define ADDR_W 10
`define DATA_W 32
`define WORD_W 16
`define RELAY_WORDS 128
`define REG_WORDS 256
`define LINK_RELAY_MAX 8'd64
`define LINK_REG_MAX 9'd128
`define MAX_STATIONS 5'd16

// Word addresses on the register port
`define A_RELAY_MEM 10'h000
`define A_REG_MEM 10'h100
`define A_LINK0_CFG 10'h200
`define A_LINK1_CFG 10'h210
`define A_SWITCH 10'h220
`define A_OWN_STATION 10'h221
`define A_OWN_RUN 10'h222
`define A_STATUS 10'h224
`define A_MASK 10'h225
`define A_ASSURE 10'h226
`define A_MODE 10'h227

// Offsets inside one link configuration block
`define C_RELAY_RANGE 4'h0
`define C_REG_RANGE 4'h1
`define C_RELAY_START 4'h2
`define C_RELAY_SIZE 4'h3
`define C_REG_START 4'h4
`define C_REG_SIZE 4'h5
`define C_MAX_STATION 4'h7

// Reset values
`define RST_MAX_STATION 5'h10
`define RST_RELAY_START0 7'h00
`define RST_RELAY_START1 7'h40
`define RST_REG_START0 8'h00
`define RST_REG_START1 8'h80

// Status bit positions: config error, link error, cycle done, two links each
`define S_CFG_ERR 0
`define S_LINK_ERR 2
`define S_CYCLE 4
`define STATUS_W 6

// Wait for a polled station before it counts as absent
`define POLL_TIMEOUT_US 100
`define CLK_MHZ 125

`endif

// file: pkg/plc_link_pkg.sv
// Types of the shared link area block
package plc_link_pkg;
   typedef enum logic [1:0] {
      POLL_IDLE = 2'b00,
      POLL_ASK = 2'b01,
      POLL_WAIT = 2'b11,
      POLL_DONE = 2'b10
   } poll_state_e;
   typedef logic [4:0] station_t;
endpackage : plc_link_pkg

// file: test/link_framer_model.sv
// Peer stations answering polls
module link_framer_model (
   input wire logic clock, // System clock
   input wire logic [1:0] pollReq, // Poll per link
   input wire plc_link_pkg::station_t pollStation [2], // Station asked
   output logic [1:0] frameValid, // Answer pulse
   output logic [1:0] frameGood, // Line checks ok
   output logic [1:0] frameRun, // Peer runs
   output logic [6:0] frameRelayStart [2], // Relay send start
   output logic [6:0] frameRelaySize [2], // Relay send size
   output logic [7:0] frameRegStart [2], // Register send start
   output logic [7:0] frameRegSize [2] // Register send size
);
   timeunit 1ns;
   timeprecision 1ps;
   import plc_link_pkg::*;
   logic [16:1] present = '0;
   logic [16:1] runs = '0;
   logic [6:0] rs [16:1];
   logic [6:0] rz [16:1];
   logic [7:0] gs [16:1];
   logic [7:0] gz [16:1];
   int delay = 1;
   initial frameValid = '0;
   for (genvar g = 0; g < 2; g++) begin : gLink
      station_t st;
      always begin
         @(posedge clock);
         st = pollStation[g];
         if (pollReq[g] === 1'b1 && present[st] === 1'b1) begin
            repeat (delay) @(posedge clock);
            frameValid[g] <= 1'b1;
            frameGood[g] <= 1'b1;
            frameRun[g] <= runs[st];
            frameRelayStart[g] <= rs[st];
            frameRelaySize[g] <= rz[st];
            frameRegStart[g] <= gs[st];
            frameRegSize[g] <= gz[st];
            @(posedge clock);
            frameValid[g] <= 1'b0;
            // Released run, relay start and register size lines show the inverse
            frameRun[g] <= ~runs[st];
            frameRelayStart[g] <= ~rs[st];
            frameRegSize[g] <= ~gz[st];
         end
      end
   end
endmodule : link_framer_model

// file: test/plc_link_area_and_status_properties.sv
// Port assertions of the link area block
`include "plc_link_defs.svh"
module plc_link_checker (
   input wire logic clock, // System clock
   input wire logic sys_rst, // Reset
   input wire logic [`ADDR_W-1:0] addr, // Address
   input wire logic rdStb, // Read strobe
   input wire logic [`DATA_W-1:0] rdData, // Read data
   input wire logic [1:0] pollReq, // Poll requests
   input wire plc_link_pkg::station_t pollStation [2], // Polled station
   input wire logic txRdReq, // Send word fetch
   input wire logic [`WORD_W-1:0] txRdData, // Fetched word
   input wire logic [15:0] assure [2], // Assurance bits
   input wire logic [15:0] runMode [2] // Mode bits
);
   import plc_link_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   poll_one_cycle_a: assert property (pollReq[0] |=> !pollReq[0])
      else $error("poll held");
   poll_bound_zero_a: assert property (pollReq[0] |-> pollStation[0] inside {[5'd1:`MAX_STATIONS]})
      else $error("bad station 0");
   poll_bound_one_a: assert property (pollReq[1] |-> pollStation[1] inside {[5'd1:`MAX_STATIONS]})
      else $error("bad station 1");
   poll_station_hold_a: assert property (pollReq[0] |=> $stable(pollStation[0]))
      else $error("station moved");
   assure_commit_a: assert property (!$stable(assure[0]) |-> !pollReq[0] && !$past(pollReq[0]))
      else $error("assure changed in poll");
   mode_commit_a: assert property (pollReq[0] |=> $stable(runMode[0]))
      else $error("mode changed after poll");
   assure_read_a: assert property (rdStb && addr == `A_ASSURE |=>
      rdData == {$past(assure[1]), $past(assure[0])})
      else $error("assure readback");
   mode_read_a: assert property (rdStb && addr == `A_MODE |=>
      rdData == {$past(runMode[1]), $past(runMode[0])})
      else $error("mode readback");
   read_quiet_a: assert property (!rdStb |=> rdData == '0)
      else $error("stray read data");
   tx_word_hold_a: assert property (!txRdReq |=> $stable(txRdData))
      else $error("send word moved");
   cover property (pollReq[0] && pollStation[0] == 5'd3);
   cover property (rdStb && addr == `A_STATUS);
   cover property (txRdReq ##1 txRdData != '0);
endmodule : plc_link_checker
bind plc_link_area_and_status plc_link_checker plc_link_checker_inst (
   .clock(clock), .sys_rst(sys_rst), .addr(addr), .rdStb(rdStb), .rdData(rdData), .pollReq(pollReq),
   .pollStation(pollStation), .txRdReq(txRdReq), .txRdData(txRdData), .assure(assure), .runMode(runMode));

// file: test/test_plc_link_area_and_status.sv
// Bench of the link area block
`include "plc_link_defs.svh"
module test_plc_link_area_and_status;
   timeunit 1ns;
   timeprecision 1ps;
   import plc_link_pkg::*;
   logic clock = 1'b0, sys_rst = 1'b1, wrStb = 1'b0, rdStb = 1'b0, rxWordValid = 1'b0;
   logic rxLink = 1'b0, rxIsReg = 1'b0, txRdReq = 1'b0, txRdIsReg = 1'b0, irq, linkErrFlag;
   logic [`ADDR_W-1:0] addr = '0;
   logic [`DATA_W-1:0] wrData = '0, rdData, d;
   logic [7:0] rxIndex = '0, txRdIndex = '0;
   logic [`WORD_W-1:0] rxData = '0, txRdData, w, mode;
   logic [1:0] pollReq, frameValid, frameGood, frameRun, txEnable;
   station_t pollStation [2];
   logic [6:0] frameRelayStart [2], frameRelaySize [2];
   logic [7:0] frameRegStart [2], frameRegSize [2];
   logic [15:0] assure [2], runMode [2];
   logic [7:0] cfg [6] = '{64, 100, 0, 20, 0, 40};
   int fails = 0, checked = 0, n, len3, polls = 0, ownPolls = 0;
   int seed = 32'hdbe0;
   always #4 clock = ~clock;
   plc_link_area_and_status #(.POLL_TIMEOUT_CYCLES(8)) plc_link_area_and_status_inst (
      .clock(clock), .sys_rst(sys_rst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
      .rdData(rdData), .irq(irq), .linkErrFlag(linkErrFlag), .pollReq(pollReq), .pollStation(pollStation),
      .frameValid(frameValid), .frameGood(frameGood), .frameRun(frameRun), .frameRelayStart(frameRelayStart),
      .frameRelaySize(frameRelaySize), .frameRegStart(frameRegStart), .frameRegSize(frameRegSize),
      .rxWordValid(rxWordValid), .rxLink(rxLink), .rxIsReg(rxIsReg), .rxIndex(rxIndex), .rxData(rxData),
      .txEnable(txEnable), .txRdReq(txRdReq), .txRdIsReg(txRdIsReg), .txRdIndex(txRdIndex),
      .txRdData(txRdData), .assure(assure), .runMode(runMode));
   link_framer_model link_framer_model_inst (
      .clock(clock), .pollReq(pollReq), .pollStation(pollStation), .frameValid(frameValid),
      .frameGood(frameGood), .frameRun(frameRun), .frameRelayStart(frameRelayStart),
      .frameRelaySize(frameRelaySize), .frameRegStart(frameRegStart), .frameRegSize(frameRegSize));
   always @(posedge clock) if (pollReq[0] === 1'b1) begin
      polls++;
      if (pollStation[0] == 5'd1) ownPolls++;
   end
   function automatic logic [15:0] exp_bits(input int top, input logic [16:1] m);
      return 16'(m) & 16'((32'h1 << top) - 1);
   endfunction : exp_bits
   task finish_test();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task wr(input logic [9:0] a, input logic [31:0] v);
      @(posedge clock);
      addr <= a;
      wrData <= v;
      wrStb <= 1'b1;
      @(posedge clock);
      wrStb <= 1'b0;
   endtask : wr
   task rd(input logic [9:0] a);
      @(posedge clock);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge clock);
      rdStb <= 1'b0;
      #1 d = rdData;
   endtask : rd
   task rx(input logic r, input logic [7:0] i, input logic [15:0] v);
      @(posedge clock);
      rxWordValid <= 1'b1;
      rxIsReg <= r;
      rxIndex <= i;
      rxData <= v;
      @(posedge clock);
      rxWordValid <= 1'b0;
      rxData <= ~v;
   endtask : rx
   task wait_bit(input int k);
      n = 0;
      do begin
         rd(`A_STATUS);
         n++;
      end while (d[k] !== 1'b1 && n < 300);
      if (n >= 300) begin
         fails++;
         finish_test();
      end
   endtask : wait_bit
   task wait_cycle();
      wr(`A_STATUS, 32'h30);
      wait_bit(`S_CYCLE);
   endtask : wait_cycle
   task set_peer(input int s, input logic [6:0] a, b, input logic [7:0] c, e);
      link_framer_model_inst.rs[s] = a;
      link_framer_model_inst.rz[s] = b;
      link_framer_model_inst.gs[s] = c;
      link_framer_model_inst.gz[s] = e;
   endtask : set_peer
   initial begin
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      rd(`A_LINK1_CFG + `C_RELAY_START);
      check(d, 32'd64);
      rd(`A_LINK1_CFG + `C_REG_START);
      check(d, 32'd128);
      rd(`A_LINK0_CFG + `C_MAX_STATION);
      check(d, 32'd16);
      rd(`A_SWITCH);
      check(d, 32'd0);
      rd(10'h3ff);
      check(d, 32'd0);
      link_framer_model_inst.present = 16'h0007;
      link_framer_model_inst.runs = 16'($random(seed));
      set_peer(1, 0, 20, 0, 40);
      set_peer(2, 20, 20, 40, 40);
      set_peer(3, 40, 24, 80, 20);
      for (int i = 0; i < 6; i++) wr(`A_LINK0_CFG + 10'(i), 32'(cfg[i]));
      wr(`A_LINK0_CFG + `C_MAX_STATION, 32'd3);
      wr(`A_OWN_RUN, 32'd1);
      wait_cycle();
      wait_cycle();
      len3 = n;
      check(32'(assure[0]), 32'h7);
      mode = exp_bits(3, link_framer_model_inst.runs) & 16'hfffe | 16'h1;
      check(32'(runMode[0]), 32'(mode));
      check(32'(txEnable), 32'h1);
      w = 16'($random(seed));
      wr(`A_RELAY_MEM + 10'd5, 32'ha5a5);
      wr(`A_REG_MEM + 10'd110, 32'h5a5a);
      // use peer data only when assured
      if (assure[0][1] === 1'b1) rx(1'b0, 8'd25, w);
      rx(1'b0, 8'd5, ~w);
      rx(1'b1, 8'd110, w);
      rd(`A_RELAY_MEM + 10'd25);
      check(d, 32'(w));
      rd(`A_RELAY_MEM + 10'd5);
      check(d, 32'ha5a5);
      rd(`A_REG_MEM + 10'd110);
      check(d, 32'h5a5a);
      @(posedge clock);
      txRdReq <= 1'b1;
      txRdIndex <= 8'd5;
      @(posedge clock);
      txRdReq <= 1'b0;
      #1 check(32'(txRdData), 32'ha5a5);
      wr(`A_LINK0_CFG + `C_MAX_STATION, 32'd4);
      wait_cycle();
      wait_cycle();
      check(32'(n > len3 + 2), 32'h1);
      check(32'(assure[0]), 32'(exp_bits(4, 16'h7)));
      wr(`A_LINK0_CFG + `C_MAX_STATION, 32'd3);
      link_framer_model_inst.delay = 5;
      set_peer(3, 30, 34, 80, 20);
      wait_cycle();
      wait_cycle();
      check(32'(assure[0]), 32'h3);
      check({30'h0, linkErrFlag, irq}, 32'h2);
      wr(`A_MASK, 32'h4);
      #1 check(32'(irq), 32'h1);
      set_peer(3, 40, 24, 80, 20);
      wait_cycle();
      wait_cycle();
      wr(`A_STATUS, 32'h3f);
      repeat (2) @(posedge clock);
      #1 check({30'h0, linkErrFlag, irq}, 32'h0);
      wr(`A_MASK, 32'h0);
      wr(`A_LINK0_CFG + `C_RELAY_START, 32'd60);
      wait_bit(`S_CFG_ERR);
      repeat (40) @(posedge clock);
      polls = 0;
      repeat (30) @(posedge clock);
      check({polls[29:0], txEnable[0], linkErrFlag}, 32'h1);
      wr(`A_LINK0_CFG + `C_RELAY_START, 32'd0);
      wr(`A_LINK0_CFG + `C_RELAY_SIZE, 32'd0);
      wr(`A_LINK0_CFG + `C_REG_SIZE, 32'd0);
      wr(`A_STATUS, 32'h3f);
      wait_cycle();
      ownPolls = 0;
      wait_cycle();
      check({ownPolls[29:0], txEnable}, 32'h0);
      check(32'(assure[0]), 32'h7);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      #1 check({assure[0], 14'h0, txEnable}, 32'h0);
      sys_rst <= 1'b0;
      finish_test();
   end
endmodule : test_plc_link_area_and_status
